// File: rtl/ocs_params.svh
// Constants for the oscillator, multiplier and clock select block
`ifndef OCS_PARAMS_SVH
`define OCS_PARAMS_SVH

// Oscillator configuration codes
`define OCS_CFG_XTAL_X4 4'h6
`define OCS_CFG_INT_ONE_PIN 4'h9
`define OCS_CFG_INT_NO_PIN 4'h8
`define OCS_CFG_RC 4'h3
`define OCS_CFG_RC_IO 4'h7
`define OCS_CFG_XTAL_HS 4'h2

// Internal frequency select codes
`define OCS_FREQ_8MHZ 3'h7
`define OCS_FREQ_4MHZ 3'h6
`define OCS_FREQ_125KHZ 3'h1
`define OCS_FREQ_31KHZ 3'h0

// Tuning register layout and reset value
`define OCS_TUNE_ORIGIN_BIT 7
`define OCS_TUNE_MULT_BIT 6
`define OCS_TUNE_TRIM_HI 4
`define OCS_TUNE_TRIM_LO 0
`define OCS_TUNE_RESET 8'h00

// Postscaler counter width and divide-by-four counter width
`define OCS_POST_WIDTH 8
`define OCS_QUARTER_WIDTH 2

// Number of asynchronous oscillator inputs that are synchronised
`define OCS_SYNC_COUNT 4
`define OCS_SYNC_RC 0
`define OCS_SYNC_FAST 1
`define OCS_SYNC_SLOW 2
`define OCS_SYNC_PIN2 3

`endif

// File: rtl/ocs_pkg.sv
// Types shared by the clock select block
package ocs_pkg;

    // Decoded oscillator mode
    typedef enum logic [2:0] {
        ocs_mode_xtal = 3'h0,
        ocs_mode_xtal_x4 = 3'h1,
        ocs_mode_rc = 3'h2,
        ocs_mode_rc_io = 3'h3,
        ocs_mode_int_one = 3'h4,
        ocs_mode_int_none = 3'h5
    } ocs_mode_t;

    // Source of the internal clock
    typedef enum logic [1:0] {
        ocs_src_fast = 2'h0,
        ocs_src_slow = 2'h1,
        ocs_src_post = 2'h2
    } ocs_src_t;

endpackage

// File: rtl/ocs_postscaler.sv
// Power-of-two postscaler for the fast internal clock
`timescale 1ns/10ps
`include "ocs_params.svh"

module ocs_postscaler (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Source clock, synchronised level and its rising edge
    input wire logic src_level,
    input wire logic src_rise,
    // Frequency select code
    input wire logic [2:0] div_code,
    // Divided clock level and its rising edge
    output logic post_level,
    output logic post_rise
);

    // Rising-edge counter of the source clock
    logic [`OCS_POST_WIDTH-1:0] count;
    // Selected divided level
    logic next_post_level;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------

    // Count source rising edges
    always_ff @(posedge clock) begin
        if (reset) begin
            count <= '0;
        end else if (src_rise) begin
            count <= count + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Divider select
    // ------------------------------------------------------------

    // Each step down to code 1 halves the frequency; code 0 divides by 256, a quarter of code 1
    always_comb begin
        case (div_code)
            3'h7: next_post_level = src_level;
            3'h6: next_post_level = count[0];
            3'h5: next_post_level = count[1];
            3'h4: next_post_level = count[2];
            3'h3: next_post_level = count[3];
            3'h2: next_post_level = count[4];
            3'h1: next_post_level = count[5];
            3'h0: next_post_level = count[7];
            default: next_post_level = src_level;
        endcase
    end

    // Register the level and flag its rising edge
    always_ff @(posedge clock) begin
        if (reset) begin
            post_level <= 1'b0;
            post_rise <= 1'b0;
        end else begin
            post_level <= next_post_level;
            post_rise <= next_post_level & ~post_level;
        end
    end

endmodule // ocs_postscaler

// File: rtl/ocs_clock_select.sv
// Oscillator mode, multiplier and internal clock select control
`timescale 1ns/10ps
`include "ocs_params.svh"

module ocs_clock_select (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Nonvolatile configuration and frequency select
    input wire logic [3:0] oscillator_config_field,
    input wire logic [2:0] internal_freq_select,
    // Tuning register write port
    input wire logic tune_write,
    input wire logic [7:0] tune_wdata,
    // Features that need the slow clock
    input wire logic power_up_timer_on,
    input wire logic fail_safe_monitor_on,
    input wire logic watchdog_on,
    input wire logic two_speed_start_on,
    input wire logic lcd_on_slow_clock,
    // Raw oscillator clocks
    input wire logic fast_osc_clock,
    input wire logic slow_osc_clock,
    // First oscillator pin
    input wire logic first_oscillator_pin_in,
    output logic first_oscillator_pin_out,
    output logic first_oscillator_pin_oe,
    // Second oscillator pin
    input wire logic second_oscillator_pin_in,
    output logic second_oscillator_pin_out,
    output logic second_oscillator_pin_oe,
    // Port A bits six and seven from the port latches
    input wire logic port_a_bit_six_latch,
    input wire logic port_a_bit_six_drive,
    input wire logic port_a_bit_seven_latch,
    input wire logic port_a_bit_seven_drive,
    output logic port_a_bit_six_read,
    output logic port_a_bit_seven_read,
    // Oscillator controls and status
    output logic fast_osc_enable,
    output logic slow_osc_enable,
    output logic [4:0] fast_trim,
    output logic crystal_mult_connect,
    output logic internal_mult_active,
    output logic [7:0] tuning_reg,
    output logic [1:0] internal_source,
    output logic system_clock_level
);

    // Synchroniser stages and edge history
    logic [`OCS_SYNC_COUNT-1:0] async_in;
    logic [`OCS_SYNC_COUNT-1:0] sync_first;
    logic [`OCS_SYNC_COUNT-1:0] sync_second;
    logic [`OCS_SYNC_COUNT-1:0] sync_prev;
    logic [`OCS_SYNC_COUNT-1:0] sync_rise;
    // Decoded mode
    ocs_pkg::ocs_mode_t mode;
    // Stored tuning bits
    logic low_freq_origin_select;
    logic multiplier_request;
    // Multiplier availability
    logic int_mult_allowed;
    // Postscaler outputs
    logic post_level;
    logic post_rise;
    // Selected internal source and resulting clock
    ocs_pkg::ocs_src_t next_source;
    logic int_level;
    logic int_rise;
    logic sys_level;
    logic sys_rise;
    // Divide-by-four counter and its output
    logic [`OCS_QUARTER_WIDTH-1:0] quarter_count;
    logic quarter_level;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------

    assign async_in[`OCS_SYNC_RC] = first_oscillator_pin_in;
    assign async_in[`OCS_SYNC_FAST] = fast_osc_clock;
    assign async_in[`OCS_SYNC_SLOW] = slow_osc_clock;
    assign async_in[`OCS_SYNC_PIN2] = second_oscillator_pin_in;

    // Two flops per input, then a third for edge detection
    genvar gi;
    generate
        for (gi = 0; gi < `OCS_SYNC_COUNT; gi = gi + 1) begin : g_sync
            always_ff @(posedge clock) begin
                if (reset) begin
                    sync_first[gi] <= 1'b0;
                    sync_second[gi] <= 1'b0;
                    sync_prev[gi] <= 1'b0;
                end else begin
                    sync_first[gi] <= async_in[gi];
                    sync_second[gi] <= sync_first[gi];
                    sync_prev[gi] <= sync_second[gi];
                end
            end
            assign sync_rise[gi] = sync_second[gi] & ~sync_prev[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------

    // Map the configuration field onto a mode
    always_comb begin
        case (oscillator_config_field)
            `OCS_CFG_XTAL_X4: mode = ocs_pkg::ocs_mode_xtal_x4;
            `OCS_CFG_RC: mode = ocs_pkg::ocs_mode_rc;
            `OCS_CFG_RC_IO: mode = ocs_pkg::ocs_mode_rc_io;
            `OCS_CFG_INT_ONE_PIN: mode = ocs_pkg::ocs_mode_int_one;
            `OCS_CFG_INT_NO_PIN: mode = ocs_pkg::ocs_mode_int_none;
            default: mode = ocs_pkg::ocs_mode_xtal;
        endcase
    end

    // Internal multiplier needs an internal mode and 8 or 4 MHz
    assign int_mult_allowed =
        ((oscillator_config_field == `OCS_CFG_INT_ONE_PIN) ||
         (oscillator_config_field == `OCS_CFG_INT_NO_PIN)) &&
        ((internal_freq_select == `OCS_FREQ_8MHZ) ||
         (internal_freq_select == `OCS_FREQ_4MHZ));

    // ------------------------------------------------------------
    // Tuning register
    // ------------------------------------------------------------

    // Store origin select, multiplier request and trim on a write
    always_ff @(posedge clock) begin
        if (reset) begin
            low_freq_origin_select <=
                1'(`OCS_TUNE_RESET >> `OCS_TUNE_ORIGIN_BIT);
            multiplier_request <= 1'(`OCS_TUNE_RESET >> `OCS_TUNE_MULT_BIT);
            fast_trim <= 5'(`OCS_TUNE_RESET >> `OCS_TUNE_TRIM_LO);
        end else if (tune_write) begin
            low_freq_origin_select <= tune_wdata[`OCS_TUNE_ORIGIN_BIT];
            multiplier_request <= tune_wdata[`OCS_TUNE_MULT_BIT];
            // Trim drives the fast oscillator at once; no busy flag
            fast_trim <=
                tune_wdata[`OCS_TUNE_TRIM_HI:`OCS_TUNE_TRIM_LO];
        end
    end

    // Read-back image; multiplier bit reads zero where unavailable
    always_ff @(posedge clock) begin
        if (reset) begin
            tuning_reg <= `OCS_TUNE_RESET;
        end else begin
            tuning_reg <= {low_freq_origin_select,
                           multiplier_request & int_mult_allowed,
                           1'b0,
                           fast_trim};
        end
    end

    // ------------------------------------------------------------
    // Multiplier control
    // ------------------------------------------------------------

    // Crystal multiplier and internal multiplier enables
    always_ff @(posedge clock) begin
        if (reset) begin
            crystal_mult_connect <= 1'b0;
            internal_mult_active <= 1'b0;
        end else begin
            crystal_mult_connect <=
                (oscillator_config_field == `OCS_CFG_XTAL_X4);
            internal_mult_active <=
                multiplier_request & int_mult_allowed;
        end
    end

    // ------------------------------------------------------------
    // Oscillator enables
    // ------------------------------------------------------------

    // Fast clock runs for 125 kHz and up, or feeds the 31 kHz option
    always_ff @(posedge clock) begin
        if (reset) begin
            fast_osc_enable <= 1'b0;
            slow_osc_enable <= 1'b0;
        end else begin
            fast_osc_enable <=
                (internal_freq_select >= `OCS_FREQ_125KHZ) ||
                low_freq_origin_select;
            slow_osc_enable <=
                ((internal_freq_select == `OCS_FREQ_31KHZ) &&
                 !low_freq_origin_select) ||
                power_up_timer_on || fail_safe_monitor_on ||
                watchdog_on || two_speed_start_on || lcd_on_slow_clock;
        end
    end

    // ------------------------------------------------------------
    // Internal source select
    // ------------------------------------------------------------

    // Postscaler on the fast clock
    ocs_postscaler u_postscaler (
        .clock(clock),
        .reset(reset),
        .src_level(sync_second[`OCS_SYNC_FAST]),
        .src_rise(sync_rise[`OCS_SYNC_FAST]),
        .div_code(internal_freq_select),
        .post_level(post_level),
        .post_rise(post_rise)
    );

    // Pick fast direct, slow direct or postscaled fast
    always_comb begin
        if (internal_freq_select == `OCS_FREQ_8MHZ) begin
            next_source = ocs_pkg::ocs_src_fast;
        end else if ((internal_freq_select == `OCS_FREQ_31KHZ) &&
                     !low_freq_origin_select) begin
            next_source = ocs_pkg::ocs_src_slow;
        end else begin
            next_source = ocs_pkg::ocs_src_post;
        end
    end

    // Selected internal clock; postscaler covers the fast direct case
    assign int_level = (next_source == ocs_pkg::ocs_src_slow) ?
        sync_second[`OCS_SYNC_SLOW] : post_level;
    assign int_rise = (next_source == ocs_pkg::ocs_src_slow) ?
        sync_rise[`OCS_SYNC_SLOW] : post_rise;

    // Publish the chosen source
    always_ff @(posedge clock) begin
        if (reset) begin
            internal_source <= ocs_pkg::ocs_src_fast;
        end else begin
            internal_source <= next_source;
        end
    end

    // ------------------------------------------------------------
    // System clock and divide by four
    // ------------------------------------------------------------

    // Internal modes use the block, others the first pin oscillator
    assign sys_level = ((mode == ocs_pkg::ocs_mode_int_one) ||
                        (mode == ocs_pkg::ocs_mode_int_none)) ?
        int_level : sync_second[`OCS_SYNC_RC];
    assign sys_rise = ((mode == ocs_pkg::ocs_mode_int_one) ||
                       (mode == ocs_pkg::ocs_mode_int_none)) ?
        int_rise : sync_rise[`OCS_SYNC_RC];

    // Count source edges for the quarter-rate output
    always_ff @(posedge clock) begin
        if (reset) begin
            quarter_count <= '0;
        end else if (sys_rise) begin
            quarter_count <= quarter_count + 1'b1;
        end
    end

    // Times four then divide by four leaves the source rate itself
    assign quarter_level = (internal_mult_active || crystal_mult_connect) ?
        sys_level : quarter_count[`OCS_QUARTER_WIDTH-1];

    // Reference level of the oscillator feeding the core
    always_ff @(posedge clock) begin
        if (reset) begin
            system_clock_level <= 1'b0;
        end else begin
            system_clock_level <= sys_level;
        end
    end

    // ------------------------------------------------------------
    // Pin ownership
    // ------------------------------------------------------------

    // Second pin: quarter clock, port bit six, or oscillator use
    always_ff @(posedge clock) begin
        if (reset) begin
            second_oscillator_pin_out <= 1'b0;
            second_oscillator_pin_oe <= 1'b0;
        end else begin
            case (mode)
                ocs_pkg::ocs_mode_rc,
                ocs_pkg::ocs_mode_int_one: begin
                    second_oscillator_pin_out <= quarter_level;
                    second_oscillator_pin_oe <= 1'b1;
                end
                ocs_pkg::ocs_mode_rc_io,
                ocs_pkg::ocs_mode_int_none: begin
                    second_oscillator_pin_out <= port_a_bit_six_latch;
                    second_oscillator_pin_oe <= port_a_bit_six_drive;
                end
                default: begin
                    second_oscillator_pin_out <= 1'b0;
                    second_oscillator_pin_oe <= 1'b0;
                end
            endcase
        end
    end

    // First pin: port bit seven in internal modes, else oscillator
    always_ff @(posedge clock) begin
        if (reset) begin
            first_oscillator_pin_out <= 1'b0;
            first_oscillator_pin_oe <= 1'b0;
        end else if ((mode == ocs_pkg::ocs_mode_int_one) ||
                     (mode == ocs_pkg::ocs_mode_int_none)) begin
            first_oscillator_pin_out <= port_a_bit_seven_latch;
            first_oscillator_pin_oe <= port_a_bit_seven_drive;
        end else begin
            first_oscillator_pin_out <= 1'b0;
            first_oscillator_pin_oe <= 1'b0;
        end
    end

    // Port reads; a bit not given to the port reads zero
    always_ff @(posedge clock) begin
        if (reset) begin
            port_a_bit_six_read <= 1'b0;
            port_a_bit_seven_read <= 1'b0;
        end else begin
            port_a_bit_six_read <= ((mode == ocs_pkg::ocs_mode_rc_io) ||
                                    (mode == ocs_pkg::ocs_mode_int_none)) &
                                   sync_second[`OCS_SYNC_PIN2];
            port_a_bit_seven_read <= ((mode == ocs_pkg::ocs_mode_int_one) ||
                                      (mode == ocs_pkg::ocs_mode_int_none)) &
                                     sync_second[`OCS_SYNC_RC];
        end
    end

    // Trim only reaches the fast oscillator; slow has no trim port

endmodule // ocs_clock_select

// File: test/ocs_osc_model.sv
// Free-running oscillator model for the pins and oscillator inputs
`timescale 1ns/10ps

module ocs_osc_model #(
    parameter real HALF_NS = 100.0
) (
    // Oscillator level
    output logic osc_level
);
    // Offset keeps edges off clock edges
    initial begin
        osc_level = 1'b0;
        #3.1;
        forever begin
            #(HALF_NS);
            osc_level = ~osc_level;
        end
    end
endmodule // ocs_osc_model

// File: test/ocs_sel_assertions.sv
// Port checker for the clock select block
`timescale 1ns/10ps
`include "ocs_params.svh"

module ocs_sel_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Design inputs
    input wire logic [3:0] oscillator_config_field,
    input wire logic [2:0] internal_freq_select,
    input wire logic tune_write,
    input wire logic [7:0] tune_wdata,
    // Design outputs
    input wire logic fast_osc_enable,
    input wire logic [4:0] fast_trim,
    input wire logic crystal_mult_connect,
    input wire logic internal_mult_active,
    input wire logic [7:0] tuning_reg,
    input wire logic [1:0] internal_source,
    input wire logic second_oscillator_pin_oe
);
    logic [1:0] up_count; // Edges since reset release
    logic live; // Outputs now follow inputs
    logic barred; // Multiplier not allowed by mode or frequency
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // Saturating count after release
    always_ff @(posedge clock) begin
        if (reset) begin
            up_count <= 2'h0;
        end else if (up_count != 2'h3) begin
            up_count <= up_count + 2'h1;
        end
    end
    assign live = (up_count == 2'h3);
    // Allowed only for codes 100x and frequency 11x
    assign barred = (oscillator_config_field[3:1] != 3'h4) ||
        (internal_freq_select[2:1] != 2'h3);

    // --------
    // Properties
    // --------
    AST_XTAL_MULT:
        assert property (live |-> crystal_mult_connect ==
            ($past(oscillator_config_field) == `OCS_CFG_XTAL_X4))
        else $error("crystal multiplier connection wrong");
    AST_MULT_GATE:
        assert property (live && internal_mult_active |-> !$past(barred))
        else $error("multiplier active while barred");
    AST_MULT_ZERO:
        assert property (live && $past(barred) && $past(barred, 2) &&
            $past(barred, 3) |-> !tuning_reg[6] && !internal_mult_active)
        else $error("multiplier enable not forced low");
    AST_TRIM_TAKE:
        assert property (live && $past(tune_write) |->
            fast_trim == $past(tune_wdata[4:0]))
        else $error("trim not taken after write");
    AST_READBACK:
        assert property (live && $past(tune_write, 2) |->
            tuning_reg[7] == $past(tune_wdata[7], 2) &&
            tuning_reg[5:0] == {1'b0, $past(tune_wdata[4:0], 2)})
        else $error("tuning read-back wrong");
    AST_FAST_ON:
        assert property (live && $past(internal_freq_select) != 3'h0 |->
            fast_osc_enable)
        else $error("fast oscillator off");
    AST_SOURCE:
        assert property (live && $past(internal_freq_select) != 3'h0 |->
            internal_source == (($past(internal_freq_select) == 3'h7) ?
            ocs_pkg::ocs_src_fast : ocs_pkg::ocs_src_post))
        else $error("internal source wrong");
    AST_PIN2_CLOCK:
        assert property (live &&
            ($past(oscillator_config_field) == `OCS_CFG_RC ||
            $past(oscillator_config_field) == `OCS_CFG_INT_ONE_PIN) |->
            second_oscillator_pin_oe)
        else $error("second pin not driving clock");
endmodule // ocs_sel_checker

bind ocs_clock_select ocs_sel_checker u_chk (.*);

// File: test/testbench.sv
// Self-checking bench for the clock select block
`timescale 1ns/10ps
`include "ocs_params.svh"

module testbench;
    // --------
    // Signals
    // --------
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [3:0] oscillator_config_field = `OCS_CFG_RC;
    logic [2:0] internal_freq_select = `OCS_FREQ_8MHZ;
    logic tune_write = 1'b0;
    logic [7:0] tune_wdata = 8'h00;
    logic [4:0] feat = 5'h00; // Slow-clock features
    logic [3:0] latch = 4'h0; // Bit seven drive, latch; bit six same
    logic [1:0] pin_in = 2'h0; // Outside levels on pins two, one
    logic rc_level, fast_osc_clock, slow_osc_clock;
    logic first_oscillator_pin_in, second_oscillator_pin_in,
        first_oscillator_pin_out, first_oscillator_pin_oe,
        second_oscillator_pin_out, second_oscillator_pin_oe,
        port_a_bit_six_read, port_a_bit_seven_read, fast_osc_enable,
        slow_osc_enable, crystal_mult_connect, internal_mult_active;
    logic [4:0] fast_trim;
    logic [7:0] tuning_reg;
    logic [1:0] internal_source;
    int mismatches = 0;
    int n_checks = 0;
    logic [31:0] seed = 32'hd3d1;
    localparam logic [3:0] CODES [6] = '{`OCS_CFG_INT_ONE_PIN,
        `OCS_CFG_INT_NO_PIN, `OCS_CFG_XTAL_X4, `OCS_CFG_RC,
        `OCS_CFG_RC_IO, `OCS_CFG_XTAL_HS};

    always #12.5 clock = ~clock;

    // Pin levels
    assign first_oscillator_pin_in = first_oscillator_pin_oe ?
        first_oscillator_pin_out :
        (oscillator_config_field[3:1] != 3'h4) ? rc_level : pin_in[0];
    assign second_oscillator_pin_in = second_oscillator_pin_oe ?
        second_oscillator_pin_out : pin_in[1];

    ocs_osc_model #(.HALF_NS(100.0)) u_rc (.osc_level(rc_level));
    ocs_osc_model #(.HALF_NS(62.5)) u_fast (.osc_level(fast_osc_clock));
    ocs_osc_model #(.HALF_NS(500.0)) u_slow (.osc_level(slow_osc_clock));
    ocs_clock_select u_dut (.*, .power_up_timer_on(feat[0]),
        .fail_safe_monitor_on(feat[1]), .watchdog_on(feat[2]),
        .two_speed_start_on(feat[3]), .lcd_on_slow_clock(feat[4]),
        .port_a_bit_six_latch(latch[0]), .port_a_bit_six_drive(latch[1]),
        .port_a_bit_seven_latch(latch[2]),
        .port_a_bit_seven_drive(latch[3]), .system_clock_level());

    // --------
    // Helpers
    // --------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Multiplier allowed
    function automatic logic allowed(input logic [3:0] c, logic [2:0] f);
        return (c == `OCS_CFG_INT_ONE_PIN || c == `OCS_CFG_INT_NO_PIN) &&
            (f == `OCS_FREQ_8MHZ || f == `OCS_FREQ_4MHZ);
    endfunction
    // Expected source
    function automatic logic [1:0] exp_src(input logic [2:0] f, logic org);
        if (f == `OCS_FREQ_8MHZ) return ocs_pkg::ocs_src_fast;
        if (f == `OCS_FREQ_31KHZ && !org) return ocs_pkg::ocs_src_slow;
        return ocs_pkg::ocs_src_post;
    endfunction
    // Pin-two rises per 320 cycles
    function automatic int exp_rises(input logic [2:0] f, logic m);
        return (16 >> (3'h7 - f)) * (m ? 4 : 1);
    endfunction
    task automatic chk_bit(input string what, logic exp, logic got);
        chk_val(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic chk_val(input string what, logic [7:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    // Two tuning writes
    task automatic tune(input logic [7:0] a, b);
        @(posedge clock);
        tune_write <= 1'b1;
        tune_wdata <= a;
        @(posedge clock);
        tune_wdata <= b;
        @(posedge clock);
        tune_write <= 1'b0;
    endtask
    task automatic count_rises(output int n);
        logic last;
        n = 0;
        last = second_oscillator_pin_out;
        repeat (320) begin
            @(negedge clock);
            if (second_oscillator_pin_out && !last) n++;
            last = second_oscillator_pin_out;
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        #400000;
        mismatches++;
        conclude();
    end

    // --------
    // Tests
    // --------
    initial begin
        logic [3:0] c;
        logic [7:0] d;
        logic ok;
        int n;
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk_val("tuning_reset", `OCS_TUNE_RESET, tuning_reg);
        @(posedge clock);
        reset <= 1'b0;
        // Modes, random latches and pins
        foreach (CODES[i]) begin
            seed = xs(seed);
            c = CODES[i];
            @(posedge clock);
            oscillator_config_field <= c;
            latch <= seed[3:0];
            pin_in <= seed[5:4];
            internal_freq_select <= seed[8:6];
            settle(6);
            chk_bit("xtal_connect", c == `OCS_CFG_XTAL_X4,
                crystal_mult_connect);
            if (c == `OCS_CFG_RC_IO || c == `OCS_CFG_INT_NO_PIN) begin
                chk_bit("pin2_oe", latch[1], second_oscillator_pin_oe);
                chk_bit("bit6_read", latch[1] ? latch[0] : pin_in[1],
                    port_a_bit_six_read);
            end
            if (c[3:1] == 3'h4) begin
                chk_bit("pin1_oe", latch[3], first_oscillator_pin_oe);
                chk_bit("bit7_read", latch[3] ? latch[2] : pin_in[0],
                    port_a_bit_seven_read);
            end
        end
        $display("test modes done");
        // Pin two clock: RC, then internal
        @(posedge clock);
        oscillator_config_field <= `OCS_CFG_RC;
        settle(8);
        count_rises(n);
        chk_bit("rc_quarter", 1'b1, n >= 9 && n <= 11);
        @(posedge clock);
        oscillator_config_field <= `OCS_CFG_INT_ONE_PIN;
        for (int i = 0; i < 5; i++) begin
            d = {1'b0, i[0], 6'h00};
            tune(d, d);
            @(posedge clock);
            internal_freq_select <= 3'(7 - i / 2);
            settle(8);
            count_rises(n);
            ok = (n - exp_rises(3'(7 - i / 2), i[0])) inside {[-1:1]};
            chk_bit("pin2_rate", 1'b1, ok);
        end
        $display("test clock out done");
        // Random tuning
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            c = CODES[seed[9:8]];
            d = seed[31:24];
            @(posedge clock);
            oscillator_config_field <= c;
            internal_freq_select <= seed[2:0];
            tune(seed[23:16], d);
            settle(3);
            ok = d[6] & allowed(c, seed[2:0]);
            chk_val("trim", {3'h0, d[4:0]}, {3'h0, fast_trim});
            chk_val("tune_read", {d[7], ok, 1'b0, d[4:0]}, tuning_reg);
            chk_bit("mult", ok, internal_mult_active);
        end
        @(posedge clock);
        oscillator_config_field <= `OCS_CFG_RC;
        tune(8'h5f, 8'h45);
        settle(3);
        chk_bit("mult_refused", 1'b0, internal_mult_active);
        @(posedge clock);
        oscillator_config_field <= `OCS_CFG_INT_NO_PIN;
        internal_freq_select <= `OCS_FREQ_4MHZ;
        settle(4);
        chk_bit("mult_back", 1'b1, internal_mult_active);
        $display("test tuning done");
        // Frequency codes, origins, features
        for (int i = 0; i < 21; i++) begin
            if (i < 16) begin
                tune({i[3], 7'h00}, {i[3], 7'h00});
            end
            @(posedge clock);
            internal_freq_select <= (i < 16) ? i[2:0] : `OCS_FREQ_8MHZ;
            feat <= (i < 16) ? 5'h00 : 5'(1 << (i - 16));
            settle(4);
            chk_bit("slow_on", (i[2:0] == 3'h0 && !i[3]) || i > 15,
                slow_osc_enable);
            if (i < 16) begin
                chk_val("source", {6'h00, exp_src(i[2:0], i[3])},
                    {6'h00, internal_source});
                chk_bit("fast_on", i[2:0] != 3'h0 || i[3],
                    fast_osc_enable);
            end
        end
        $display("test frequency select done");
        conclude();
    end
endmodule // testbench
